// [shared/pgc_pkg.sv]
// Package: addresses, field positions and reset values of the GPIO control block
package pgc_pkg;
  // ---------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] PGC_ADDR_PIN12 = 8'h1b;
  localparam logic [7:0] PGC_ADDR_PIN3 = 8'h1c;

  // ---------------------------------------------------------------
  // Field positions, pin12_direction_level_roles
  // ---------------------------------------------------------------
  localparam int PGC_PIN_TWO_DIR = 7;
  localparam int PGC_PIN_ONE_DIR = 6;
  localparam int PGC_PIN_TWO_OUT_LEVEL = 5;
  localparam int PGC_PIN_ONE_OUT_LEVEL = 4;
  localparam int PGC_PIN_TWO_POLARITY = 3;
  localparam int PGC_PIN_ONE_POLARITY = 2;
  localparam int PGC_PIN_ONE_STANDBY_ROLE = 1;
  localparam int PGC_PIN_ONE_BUCK_A_ROLE = 0;

  // ---------------------------------------------------------------
  // Field positions, pin3_and_misc_control
  // ---------------------------------------------------------------
  localparam int PGC_PIN_THREE_DIR = 7;
  localparam int PGC_PIN_THREE_OUT_LEVEL = 6;
  localparam int PGC_AUX_REGULATOR_ENABLE = 5;
  localparam int PGC_CHARGE_VOLTAGE_SELECT = 4;
  localparam int PGC_PIN_TWO_IRQ_ROLE = 2;
  localparam int PGC_PIN_ONE_IRQ_ROLE = 1;
  localparam int PGC_PIN_TWO_BUCK_B_ROLE = 0;

  // ---------------------------------------------------------------
  // Reset values: all pins inputs, no role selected
  // ---------------------------------------------------------------
  localparam logic [7:0] PGC_PIN12_RESET = 8'h00;
  localparam logic [7:0] PGC_PIN3_RESET = 8'h00;
  localparam logic [7:0] PGC_RDATA_UNMAPPED = 8'h00;
endpackage

// [design/pgc_gpio_ctrl.sv]
// GPIO control block: three open-drain pins, interrupt roles, buck control and ADC trigger
`timescale 1ns/1ps
`default_nettype none

module pgc_gpio_ctrl (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Register port from the I2C engine
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Open-drain pins, index 0 is pin one
  input wire logic [2:0] pin_in,
  output logic [2:0] pin_out,
  output logic [2:0] pin_oe,
  // Interrupt controller side
  input wire logic [1:0] irq_mask,
  input wire logic uvlo_event,
  output logic irq_n,
  // ADC side
  input wire logic adc_ext_trig_sel,
  input wire logic adc_trig_edge_sel,
  output logic adc_start,
  // Converter commands
  input wire logic buck_a_reg_en,
  input wire logic buck_b_reg_en,
  input wire logic buck_reg_standby,
  output logic buck_a_en,
  output logic buck_b_en,
  output logic buck_standby
);
  import pgc_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] cfg12;
    logic [7:0] cfg3;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] prev;
    logic [1:0] pend;
    logic [1:0] second;
    logic irq_n;
    logic [2:0] oe;
    logic [2:0] out;
    logic [7:0] rdata;
    logic adc_start;
    logic buck_a_en;
    logic buck_b_en;
    logic buck_standby;
  } pgc_state_type;

  pgc_state_type state_reg;
  pgc_state_type state_next;

  // ---------------------------------------------------------------
  // Decoded fields and events
  // ---------------------------------------------------------------
  logic [2:0] dir;
  logic [2:0] lvl;
  logic [1:0] pol;
  logic [1:0] irq_role;
  logic [1:0] irq_edge;
  logic [1:0] any_edge;
  logic [1:0] to_output;
  logic adc_edge;
  logic a_req;
  logic b_req;
  logic sb_req;

  assign dir = {state_reg.cfg3[PGC_PIN_THREE_DIR], state_reg.cfg12[PGC_PIN_TWO_DIR],
                state_reg.cfg12[PGC_PIN_ONE_DIR]};
  assign lvl = {state_reg.cfg3[PGC_PIN_THREE_OUT_LEVEL],
                state_reg.cfg12[PGC_PIN_TWO_OUT_LEVEL], state_reg.cfg12[PGC_PIN_ONE_OUT_LEVEL]};
  assign pol = {state_reg.cfg12[PGC_PIN_TWO_POLARITY], state_reg.cfg12[PGC_PIN_ONE_POLARITY]};
  assign irq_role = {state_reg.cfg3[PGC_PIN_TWO_IRQ_ROLE],
                     state_reg.cfg3[PGC_PIN_ONE_IRQ_ROLE]} & ~dir[1:0];

  // Edge detect on the second latch stage; polarity 0 rising, 1 falling
  assign irq_edge[0] = irq_role[0] & (pol[0] ? (~state_reg.sync2[0] & state_reg.prev[0])
                                             : (state_reg.sync2[0] & ~state_reg.prev[0]));
  assign irq_edge[1] = irq_role[1] & (pol[1] ? (~state_reg.sync2[1] & state_reg.prev[1])
                                             : (state_reg.sync2[1] & ~state_reg.prev[1]));
  // Any edge after the first counts as the second one, so one pulse arms the clear
  assign any_edge = irq_role & (state_reg.sync2[1:0] ^ state_reg.prev[1:0]);

  // ADC trigger: edge bit high picks the rising edge here, unlike pins one and two
  assign adc_edge = ~dir[2] & adc_ext_trig_sel &
                    (adc_trig_edge_sel ? (state_reg.sync2[2] & ~state_reg.prev[2])
                                       : (~state_reg.sync2[2] & state_reg.prev[2]));

  // A write that turns an interrupt pin into an output releases its request
  assign to_output[0] = reg_wr && (reg_addr == PGC_ADDR_PIN12) && reg_wdata[PGC_PIN_ONE_DIR];
  assign to_output[1] = reg_wr && (reg_addr == PGC_ADDR_PIN12) && reg_wdata[PGC_PIN_TWO_DIR];

  // Pin requests; a pin without its role enabled leaves the register in charge
  assign a_req = ~(state_reg.cfg12[PGC_PIN_ONE_BUCK_A_ROLE] & ~dir[0]) |
                 (state_reg.sync2[0] == pol[0]);
  assign b_req = ~(state_reg.cfg3[PGC_PIN_TWO_BUCK_B_ROLE] & ~dir[1]) |
                 (state_reg.sync2[1] == pol[1]);
  assign sb_req = ~(state_reg.cfg12[PGC_PIN_ONE_STANDBY_ROLE] & ~dir[0]) |
                  (state_reg.sync2[0] == pol[0]);

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    // Register writes and registered read data
    if (reg_wr && reg_addr == PGC_ADDR_PIN12) begin
      state_next.cfg12 = reg_wdata;
    end
    if (reg_wr && reg_addr == PGC_ADDR_PIN3) begin
      state_next.cfg3 = reg_wdata;
    end
    if (reg_rd) begin
      unique case (reg_addr)
        PGC_ADDR_PIN12: state_next.rdata = state_reg.cfg12;
        PGC_ADDR_PIN3: state_next.rdata = state_reg.cfg3;
        default: state_next.rdata = PGC_RDATA_UNMAPPED;
      endcase
    end
    // Two latch stages, then one more stage kept for edge detection
    state_next.sync1 = pin_in;
    state_next.sync2 = state_reg.sync1;
    state_next.prev = state_reg.sync2;
    // Interrupt sequence per pin: selected edge asserts, next edge of either kind arms the clear
    for (int i = 0; i < 2; i++) begin
      if (reg_rd && state_reg.second[i]) begin
        state_next.pend[i] = 1'b0;
        state_next.second[i] = 1'b0;
      end
      if (irq_edge[i] && (!state_reg.pend[i] || (reg_rd && state_reg.second[i]))) begin
        state_next.pend[i] = 1'b1;
      end else if (any_edge[i] && state_reg.pend[i] && !state_reg.second[i]) begin
        state_next.second[i] = 1'b1;
      end
      // Undervoltage and output reconfiguration override everything
      if (uvlo_event || to_output[i] || dir[i]) begin
        state_next.pend[i] = 1'b0;
        state_next.second[i] = 1'b0;
      end
    end
    state_next.irq_n = ~|(state_next.pend & ~irq_mask);
    // Open drain: enable means pulling low
    state_next.out = 3'h0;
    state_next.oe = dir & ~lvl;
    state_next.adc_start = adc_edge;
    state_next.buck_a_en = buck_a_reg_en & a_req;
    state_next.buck_b_en = buck_b_reg_en & b_req;
    state_next.buck_standby = buck_reg_standby & sb_req;
  end

  // ---------------------------------------------------------------
  // State register; reset leaves every pin an input with no role
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_reg <= '0;
      state_reg.cfg12 <= PGC_PIN12_RESET;
      state_reg.cfg3 <= PGC_PIN3_RESET;
      state_reg.irq_n <= 1'b1;
      // Pins idle high through their pull-ups; starting low would fake an edge
      state_reg.sync1 <= '1;
      state_reg.sync2 <= '1;
      state_reg.prev <= '1;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata = state_reg.rdata;
  assign pin_out = state_reg.out;
  assign pin_oe = state_reg.oe;
  assign irq_n = state_reg.irq_n;
  assign adc_start = state_reg.adc_start;
  assign buck_a_en = state_reg.buck_a_en;
  assign buck_b_en = state_reg.buck_b_en;
  assign buck_standby = state_reg.buck_standby;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_oe_follows_cfg;
    @(posedge clk_sys) disable iff (!nrst)
    1'b1 |=> pin_oe == $past(dir & ~lvl);
  endproperty
  a_oe_follows_cfg: assert property (p_oe_follows_cfg)
    else $error("pin enable does not match direction and level");

  property p_inputs_release;
    @(posedge clk_sys) disable iff (!nrst)
    (dir == 3'h0) |=> (pin_oe == 3'h0);
  endproperty
  a_inputs_release: assert property (p_inputs_release)
    else $error("input pin is being driven");

  property p_two_stages;
    @(posedge clk_sys) disable iff (!nrst)
    ##2 state_reg.sync2 == $past(pin_in, 2);
  endproperty
  a_two_stages: assert property (p_two_stages)
    else $error("sync stage not two cycles behind pin");

  property p_first_edge_irq;
    @(posedge clk_sys) disable iff (!nrst)
    (irq_edge[0] && !irq_mask[0] && !uvlo_event && !to_output[0]) ##1 !irq_mask[0]
      |-> !irq_n;
  endproperty
  a_first_edge_irq: assert property (p_first_edge_irq)
    else $error("interrupt not asserted after edge");

  property p_hold_without_read;
    @(posedge clk_sys) disable iff (!nrst)
    (state_reg.pend[0] && !reg_rd && !uvlo_event && !reg_wr && !dir[0])
      |=> state_reg.pend[0];
  endproperty
  a_hold_without_read: assert property (p_hold_without_read)
    else $error("interrupt request dropped without read");

  property p_clear_cause;
    @(posedge clk_sys) disable iff (!nrst)
    $fell(state_reg.pend[1]) |-> $past((reg_rd && state_reg.second[1]) || uvlo_event
                                       || to_output[1] || dir[1]);
  endproperty
  a_clear_cause: assert property (p_clear_cause)
    else $error("interrupt request cleared without cause");

  property p_uvlo_clears;
    @(posedge clk_sys) disable iff (!nrst)
    uvlo_event |=> (state_reg.pend == 2'h0) && irq_n;
  endproperty
  a_uvlo_clears: assert property (p_uvlo_clears)
    else $error("undervoltage did not release interrupt");

  property p_buck_merge;
    @(posedge clk_sys) disable iff (!nrst)
    (!buck_a_reg_en || !a_req) |=> !buck_a_en;
  endproperty
  a_buck_merge: assert property (p_buck_merge)
    else $error("buck_a enabled against a disable command");

  property p_standby_merge;
    @(posedge clk_sys) disable iff (!nrst)
    buck_standby |-> $past(buck_reg_standby && sb_req);
  endproperty
  a_standby_merge: assert property (p_standby_merge)
    else $error("standby entered without both requests");

  property p_adc_trigger;
    @(posedge clk_sys) disable iff (!nrst)
    adc_start |-> $past(adc_ext_trig_sel && !dir[2]);
  endproperty
  a_adc_trigger: assert property (p_adc_trigger)
    else $error("ADC start without trigger role");

  property p_readback;
    @(posedge clk_sys) disable iff (!nrst)
    (reg_rd && reg_addr == PGC_ADDR_PIN3) |=> reg_rdata == $past(state_reg.cfg3);
  endproperty
  a_readback: assert property (p_readback)
    else $error("register readback mismatch");
endmodule

`default_nettype wire

// [bench/pgc_pin_env.sv]
// Far-side model of the three open-drain pins: pull-ups plus external pull-down drivers
`timescale 1ns/1ps
`default_nettype none
module pgc_pin_env (
  // Device side
  input wire logic [2:0] pin_oe,
  input wire logic [2:0] pin_out,
  // External drivers, high pulls the wire low
  input wire logic [2:0] ext_low,
  // Resolved wire levels
  output logic [2:0] pin_lvl
);
  // Wired-AND with pull-up; a released wire never keeps an old value
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pin_lvl[i] = (pin_oe[i] || ext_low[i]) ? pin_out[i] & 1'b0 : 1'b1;
    end
  end
endmodule
`default_nettype wire

// [bench/pgc_gpio_ctrl_bench.sv]
// Self-checking testbench of the GPIO control block
`timescale 1ns/1ps
`default_nettype none
module pgc_gpio_ctrl_bench;
  import pgc_pkg::*;
  logic clk_sys, nrst, reg_wr, reg_rd, uvlo_event, irq_n, adc_start;
  logic adc_ext_trig_sel, adc_trig_edge_sel, buck_a_reg_en, buck_b_reg_en, buck_reg_standby;
  logic buck_a_en, buck_b_en, buck_standby;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
  logic [2:0] pin_in, pin_out, pin_oe, ext_low;
  logic [1:0] irq_mask;
  int errors, samples_checked, cycles, adc_cnt;
  pgc_gpio_ctrl pgc_gpio_ctrl_i (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq_mask(irq_mask),
    .uvlo_event(uvlo_event), .irq_n(irq_n), .adc_ext_trig_sel(adc_ext_trig_sel),
    .adc_trig_edge_sel(adc_trig_edge_sel), .adc_start(adc_start),
    .buck_a_reg_en(buck_a_reg_en), .buck_b_reg_en(buck_b_reg_en),
    .buck_reg_standby(buck_reg_standby), .buck_a_en(buck_a_en), .buck_b_en(buck_b_en),
    .buck_standby(buck_standby));
  pgc_pin_env pgc_pin_env_i (.pin_oe(pin_oe), .pin_out(pin_out), .ext_low(ext_low),
    .pin_lvl(pin_in));
  // ---------------------------------------------------------------
  // Clock, timeout and ADC pulse counter
  // ---------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Ceiling well above the roughly 160 cycles the tests need
  always @(posedge clk_sys) begin
    cycles++;
    if (adc_start === 1'b1) adc_cnt++;
    if (cycles == 3000) begin
      errors++;
      $display("[ERR] %0t timeout", $time);
      finish_test();
    end
  end
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // One-cycle write strobe, inputs moved 1 ns after the edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask
  // Data is registered at the read edge, so it is settled 1 ns later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    d = reg_rdata;
    tick(1);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Move pin levels and wait past the three-cycle sync and edge path
  task automatic pins(input logic [2:0] lo);
    ext_low = lo;
    tick(4);
  endtask
  task automatic finish_test();
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {nrst, reg_wr, reg_rd, uvlo_event} = '0;
    // Trigger armed for rising edges through reset to catch a false edge after release
    adc_ext_trig_sel = 1'b1;
    adc_trig_edge_sel = 1'b1;
    {buck_a_reg_en, buck_b_reg_en, buck_reg_standby, irq_mask} = '0;
    {reg_addr, reg_wdata, ext_low, cycles, adc_cnt, errors, samples_checked} = '0;
    tick(4);
    nrst = 1'b1;
    tick(1);
    // Reset state and unmapped read
    rd(PGC_ADDR_PIN12, rd_val); chk(rd_val, PGC_PIN12_RESET, "cfg12");
    rd(PGC_ADDR_PIN3, rd_val); chk(rd_val, PGC_PIN3_RESET, "cfg3");
    rd(8'h1d, rd_val); chk(rd_val, PGC_RDATA_UNMAPPED, "unmapped");
    chk({5'h0, pin_oe, irq_n}, 8'h01, "idle pins");
    chk(adc_cnt[7:0], 8'h00, "no false trigger");
    chk({5'h0, pin_out}, 8'h00, "pin_out low");
    wr(8'h1d, 8'hff); rd(PGC_ADDR_PIN12, rd_val); chk(rd_val, 8'h00, "no alias");
    $display("test reset done");
    // Outputs: driven low when level bit low, released when high
    wr(PGC_ADDR_PIN12, 8'h80); chk({5'h0, pin_oe}, 8'h02, "pin two low");
    wr(PGC_ADDR_PIN12, 8'hc0); chk({5'h0, pin_oe}, 8'h03, "pins low");
    wr(PGC_ADDR_PIN12, 8'hf0); chk({5'h0, pin_oe}, 8'h00, "released");
    wr(PGC_ADDR_PIN3, 8'hb0); chk({5'h0, pin_oe}, 8'h04, "pin three low");
    rd(PGC_ADDR_PIN3, rd_val); chk(rd_val, 8'hb0, "cfg3 back");
    wr(PGC_ADDR_PIN3, 8'hf0); chk({5'h0, pin_oe}, 8'h00, "pin three rel");
    wr(PGC_ADDR_PIN12, 8'h00); wr(PGC_ADDR_PIN3, 8'h00);
    $display("test outputs done");
    // Rising-edge interrupt on pin one, one role only per pin
    pins(3'b001);
    wr(PGC_ADDR_PIN3, 8'h02);
    pins(3'b000); chk({7'h0, irq_n}, 8'h00, "irq set");
    rd(PGC_ADDR_PIN3, rd_val); chk({7'h0, irq_n}, 8'h00, "early read");
    pins(3'b001); chk({7'h0, irq_n}, 8'h00, "second edge");
    pins(3'b000); chk({7'h0, irq_n}, 8'h00, "third edge");
    rd(PGC_ADDR_PIN12, rd_val); chk({7'h0, irq_n}, 8'h01, "cleared");
    // Falling polarity, undervoltage clear, mask and output clear
    wr(PGC_ADDR_PIN12, 8'h04);
    pins(3'b001); chk({7'h0, irq_n}, 8'h00, "fall set");
    uvlo_event = 1'b1; tick(1); uvlo_event = 1'b0;
    tick(1); chk({7'h0, irq_n}, 8'h01, "uvlo clr");
    irq_mask = 2'b01;
    pins(3'b000); chk({7'h0, irq_n}, 8'h01, "rise ignored");
    pins(3'b001); chk({7'h0, irq_n}, 8'h01, "masked");
    irq_mask = 2'b00; tick(2); chk({7'h0, irq_n}, 8'h00, "unmasked");
    wr(PGC_ADDR_PIN12, 8'h44); tick(1); chk({7'h0, irq_n}, 8'h01, "output clr");
    // Pin two, rising edge
    wr(PGC_ADDR_PIN12, 8'h00); wr(PGC_ADDR_PIN3, 8'h04);
    pins(3'b010); pins(3'b000); chk({7'h0, irq_n}, 8'h00, "pin two irq");
    pins(3'b010); rd(PGC_ADDR_PIN3, rd_val); chk({7'h0, irq_n}, 8'h01, "pin two clr");
    wr(PGC_ADDR_PIN3, 8'h00); pins(3'b000);
    $display("test interrupt done");
    // ADC trigger on pin three, both edge selections
    adc_ext_trig_sel = 1'b1; adc_trig_edge_sel = 1'b1; adc_cnt = 0;
    pins(3'b100); pins(3'b000); chk(adc_cnt[7:0], 8'h01, "adc rising");
    adc_trig_edge_sel = 1'b0;
    pins(3'b100); pins(3'b000); chk(adc_cnt[7:0], 8'h02, "adc falling");
    adc_ext_trig_sel = 1'b0;
    pins(3'b100); pins(3'b000); chk(adc_cnt[7:0], 8'h02, "adc off");
    $display("test adc done");
    // Converter merge: pin level and register command must both agree
    buck_a_reg_en = 1'b1; buck_b_reg_en = 1'b1; buck_reg_standby = 1'b1;
    wr(PGC_ADDR_PIN12, 8'h01);
    pins(3'b001); chk({7'h0, buck_a_en}, 8'h01, "a on low");
    pins(3'b000); chk({7'h0, buck_a_en}, 8'h00, "a off high");
    pins(3'b001); buck_a_reg_en = 1'b0;
    tick(2); chk({7'h0, buck_a_en}, 8'h00, "a reg off");
    wr(PGC_ADDR_PIN12, 8'h06);
    pins(3'b000); chk({7'h0, buck_standby}, 8'h01, "stby high");
    pins(3'b001); chk({7'h0, buck_standby}, 8'h00, "stby low");
    wr(PGC_ADDR_PIN12, 8'h08); wr(PGC_ADDR_PIN3, 8'h01);
    pins(3'b000); chk({7'h0, buck_b_en}, 8'h01, "b on high");
    pins(3'b010); chk({7'h0, buck_b_en}, 8'h00, "b off low");
    $display("test converters done");
    finish_test();
  end
endmodule
`default_nettype wire
